// ---- core/pvs_bank.sv ----
// Status registers and indirect subsystem access of the synthesizer register bank.
`timescale 1ns/100ps
`include "pvs_regs.svh"
module pvs_bank #(
    parameter int SWITCH_W = 8 // Width of the switch setting field.
) (
    input  wire logic                core_clk_i,    // System clock, 50 MHz.
    input  wire logic                reset_i,       // Asynchronous reset, active high.
    input  wire logic                wr_i,          // Register write strobe, one cycle.
    input  wire logic                rd_i,          // Register read strobe, one cycle.
    input  wire pvs_pkg::pvs_addr_t  addr_i,        // Register address.
    input  wire pvs_pkg::pvs_word_t  wdata_i,       // Write data.
    output pvs_pkg::pvs_word_t       rdata_o,       // Registered read data.
    input  wire logic                cal_start_i,   // Autocalibration search begins, pulse.
    input  wire logic                cal_done_i,    // Autocalibration search ends, pulse.
    input  wire logic [SWITCH_W-1:0] cal_switch_i,  // Switch setting found by the search.
    input  wire logic [19:0]         cal_error_i,   // Sign and magnitude of error count.
    input  wire logic                gen_out_i,     // General output state, asynchronous.
    input  wire logic                lock_i,        // Lock detect, asynchronous.
    output logic                     cal_voltage_o, // Tune from calibration voltage.
    output logic [7:0]               subband_o,     // Oscillator subband select.
    output logic                     osc_en_o,      // Oscillator enable.
    output logic                     fb_buf_en_o,   // Buffer to feedback divider enable.
    output logic                     out_div_en_o,  // Output divider enable.
    output logic                     out_stage_en_o // Output stage enable.
);
    import pvs_pkg::*;

    pvs_cal_e          cal_state_reg, cal_state_next;
    logic [7:0]        switch_reg;
    logic [19:0]       error_reg;
    pvs_sub_t          tuning, enable;
    logic              gen_out_s, lock_s;

    // Indirect write decode: only the oscillator subsystem identifier is forwarded.
    wire               sub_wr   = wr_i && (addr_i == `PVS_OFS_INDIRECT) &&
                         (wdata_i[`PVS_SUB_ID_MSB:`PVS_SUB_ID_LSB] == `PVS_SUB_ID_OSC);
    wire [3:0]         sub_addr = wdata_i[`PVS_SUB_ADDR_MSB:`PVS_SUB_ADDR_LSB];
    // The top bit of the forwarded data field has no register bit behind it and is dropped.
    wire pvs_sub_t     sub_data = pvs_sub_t'(wdata_i[`PVS_SUB_DATA_MSB:`PVS_SUB_DATA_LSB]);
    wire               busy     = (cal_state_reg == PVS_CAL_SEARCH);

    pvs_subsys u_subsys (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .wr_i       (sub_wr),
        .addr_i     (sub_addr),
        .data_i     (sub_data),
        .tuning_o   (tuning),
        .enable_o   (enable)
    );

    pvs_sync u_sync_gen (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .d_i        (gen_out_i),
        .q_o        (gen_out_s)
    );

    pvs_sync u_sync_lock (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .d_i        (lock_i),
        .q_o        (lock_s)
    );

    // Autocalibration tracking: searching, then finished.
    always_comb begin
        cal_state_next = cal_state_reg;
        case (cal_state_reg)
            PVS_CAL_IDLE, PVS_CAL_DONE: begin
                if (cal_start_i) cal_state_next = PVS_CAL_SEARCH;
            end
            PVS_CAL_SEARCH: begin
                if (cal_done_i) cal_state_next = PVS_CAL_DONE;
            end
            default: cal_state_next = PVS_CAL_IDLE;
        endcase
    end

    // Switch result updates together with leaving the search state.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cal_state_reg <= PVS_CAL_IDLE;
            switch_reg    <= `PVS_RST_SWITCH;
            error_reg     <= `PVS_RST_ERROR;
        end else begin
            cal_state_reg <= cal_state_next;
            if (busy && cal_done_i) begin
                switch_reg <= 8'(cal_switch_i);
                error_reg  <= cal_error_i;
            end
        end
    end

    // Read mux; subsystem registers have no read path.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 24'h000000;
        end else if (rd_i) begin
            case (addr_i)
                `PVS_OFS_SWITCH:   rdata_o <= {15'h0000, busy, switch_reg};
                `PVS_OFS_ERROR:    rdata_o <= {4'h0, error_reg};
                `PVS_OFS_STATUS:   rdata_o <= {22'h000000, lock_s, gen_out_s};
                `PVS_OFS_SELFTEST: rdata_o <= `PVS_RST_SELFTEST;
                default:           rdata_o <= 24'h000000;
            endcase
        end
    end

    // Master enable gates every subsystem block.
    assign cal_voltage_o  = tuning[`PVS_TUNE_CAL];
    assign subband_o      = tuning[`PVS_TUNE_SUB_MSB:`PVS_TUNE_SUB_LSB];
    assign osc_en_o       = enable[`PVS_EN_MASTER] & enable[`PVS_EN_OSC];
    assign fb_buf_en_o    = enable[`PVS_EN_MASTER] & enable[`PVS_EN_FBBUF];
    assign out_div_en_o   = enable[`PVS_EN_MASTER] & enable[`PVS_EN_IO];
    assign out_stage_en_o = enable[`PVS_EN_MASTER] & enable[`PVS_EN_IO] &
                            enable[`PVS_EN_OUTSTAGE];
endmodule

// ---- core/pvs_regs.svh ----
// Register offsets, field positions and reset values of the oscillator status and control bank.
// Function
// - Switch status bits 7:0 report autocalibration's chosen switch setting, reset 32.
// - Manual switch changes do not alter the reported autocalibration result.
// - Code 0 is highest oscillator frequency, 255 the lowest.
// - Busy bit 8 is high while autocalibration searches, reset zero.
// - Error register: 19-bit magnitude in 18:0, sign at bit 19.
// - Status 0x12: general output state at bit 0, lock at bit 1.
// - Subsystem registers reached only through writes to main register 0x05.
// - Subsystem tuning and enable registers are write-only, no readback.
// - Tuning bit 0 selects calibration voltage instead of loop voltage, reset 0.
// - Tuning bits 8:1 select subband, 0 fastest, all ones slowest, reset 16.
// - Enable bit 0 clear turns off every subsystem block, reset 1.
// - Enable bit 2 enables buffer to feedback divider, reset 1.
// - Enable bit 3 enables output stage and divider, not the oscillator.
// - Enable bit 5 clear disables only the output stage.
`ifndef PVS_REGS_SVH
`define PVS_REGS_SVH
`define PVS_ADDR_W         6
`define PVS_DATA_W         24
`define PVS_OFS_INDIRECT   6'h05
`define PVS_OFS_SWITCH     6'h10
`define PVS_OFS_ERROR      6'h11
`define PVS_OFS_STATUS     6'h12
`define PVS_OFS_SELFTEST   6'h13
`define PVS_SUB_ID_LSB     0
`define PVS_SUB_ID_MSB     2
`define PVS_SUB_ADDR_LSB   3
`define PVS_SUB_ADDR_MSB   6
`define PVS_SUB_DATA_LSB   7
`define PVS_SUB_DATA_MSB   16
`define PVS_SUB_ID_OSC     3'h0
`define PVS_SUB_TUNING     4'h0
`define PVS_SUB_ENABLE     4'h1
`define PVS_RST_TUNING     9'h020
`define PVS_RST_ENABLE     9'h1FF
`define PVS_RST_SWITCH     8'h20
`define PVS_RST_ERROR      20'h7FFFF
`define PVS_RST_SELFTEST   24'h001259
`define PVS_ERR_MAG_MSB    18
`define PVS_ERR_SIGN       19
`define PVS_TUNE_CAL       0
`define PVS_TUNE_SUB_LSB   1
`define PVS_TUNE_SUB_MSB   8
`define PVS_EN_MASTER      0
`define PVS_EN_OSC         1
`define PVS_EN_FBBUF       2
`define PVS_EN_IO          3
`define PVS_EN_OUTSTAGE    5
`endif

// ---- core/pvs_pkg.sv ----
// Types shared by the oscillator status and control bank.
package pvs_pkg;
    typedef logic [5:0]  pvs_addr_t;
    typedef logic [23:0] pvs_word_t;
    typedef logic [8:0]  pvs_sub_t;
    typedef enum logic [1:0] {PVS_CAL_IDLE, PVS_CAL_SEARCH, PVS_CAL_DONE} pvs_cal_e;
endpackage

// ---- core/pvs_subsys.sv ----
// Write-only oscillator subsystem registers fed by indirect writes.
`timescale 1ns/100ps
`include "pvs_regs.svh"
module pvs_subsys (
    input  wire logic              core_clk_i, // System clock.
    input  wire logic              reset_i,    // Asynchronous reset, active high.
    input  wire logic              wr_i,       // Forwarded subsystem write strobe.
    input  wire logic [3:0]        addr_i,     // Subsystem register address.
    input  wire pvs_pkg::pvs_sub_t data_i,     // Subsystem register data.
    output pvs_pkg::pvs_sub_t      tuning_o,   // Tuning register contents.
    output pvs_pkg::pvs_sub_t      enable_o    // Enable register contents.
);
    import pvs_pkg::*;

    wire wr_tuning = wr_i && (addr_i == `PVS_SUB_TUNING);
    wire wr_enable = wr_i && (addr_i == `PVS_SUB_ENABLE);

    // Registers hold values only; nothing reads them back to the port.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tuning_o <= `PVS_RST_TUNING;
            enable_o <= `PVS_RST_ENABLE;
        end else begin
            if (wr_tuning) tuning_o <= data_i;
            if (wr_enable) enable_o <= data_i;
        end
    end
endmodule

// ---- core/pvs_sync.sv ----
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/100ps
module pvs_sync (
    input  wire logic core_clk_i, // System clock.
    input  wire logic reset_i,    // Asynchronous reset, active high.
    input  wire logic d_i,        // Asynchronous input.
    output logic      q_o         // Filtered synchronous level.
);
    logic s1_reg, s2_reg, s3_reg;

    // The first stage feeds only the second.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) q_o <= s3_reg;
        end
    end
endmodule

// ---- verification/pvs_bank_chk.sv ----
// Concurrent checks on the ports of the oscillator status and control bank.
`timescale 1ns/100ps
module pvs_bank_chk (
    input wire logic               core_clk_i,    // System clock.
    input wire logic               reset_i,       // Reset, active high.
    input wire logic               wr_i,          // Write strobe.
    input wire logic               rd_i,          // Read strobe.
    input wire pvs_pkg::pvs_addr_t addr_i,        // Register address.
    input wire pvs_pkg::pvs_word_t wdata_i,       // Write data.
    input wire pvs_pkg::pvs_word_t rdata_o,       // Read data.
    input wire logic               cal_voltage_o, // Calibration voltage select.
    input wire logic [7:0]         subband_o,     // Subband select.
    input wire logic               osc_en_o,      // Oscillator enable.
    input wire logic               fb_buf_en_o,   // Feedback buffer enable.
    input wire logic               out_div_en_o,  // Output divider enable.
    input wire logic               out_stage_en_o // Output stage enable.
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // Decode of forwarded writes to the two subsystem registers.
    wire        sub_wr = wr_i && addr_i == 6'h05 && wdata_i[2:0] == 3'h0;
    wire        tun_wr = sub_wr && wdata_i[6:3] == 4'h0;
    wire        ena_wr = sub_wr && wdata_i[6:3] == 4'h1;
    wire [8:0]  sd     = wdata_i[15:7];
    wire [12:0] ctl    = {subband_o, cal_voltage_o, osc_en_o, fb_buf_en_o,
                          out_div_en_o, out_stage_en_o};
    tune_write_a: assert property (tun_wr |=> {subband_o, cal_voltage_o} == $past(sd))
        else $error("tuning write not applied");
    master_off_a: assert property (ena_wr && !wdata_i[7] |=> ctl[3:0] == 4'h0)
        else $error("master enable clear left a block on");
    fb_buffer_a: assert property (ena_wr |=> fb_buf_en_o == $past(wdata_i[7] & wdata_i[9]))
        else $error("feedback buffer enable wrong");
    io_master_a: assert property (ena_wr && sd[0] |=>
        {osc_en_o, out_div_en_o} == $past({sd[1], sd[3]}))
        else $error("output divider or oscillator enable wrong");
    out_stage_a: assert property (ena_wr |=>
        out_stage_en_o == $past(&{sd[0], sd[3], sd[5]}))
        else $error("output stage enable wrong");
    ignored_wr_a: assert property (!(tun_wr || ena_wr) |=> $stable(ctl))
        else $error("controls changed without a forwarded write");
    no_readback_a: assert property (rd_i && addr_i < 6'h02 |=> rdata_o == 24'h0)
        else $error("subsystem register read back");
    switch_fmt_a: assert property (rd_i && addr_i == 6'h10 |=> rdata_o[23:9] == 15'h0)
        else $error("switch status upper bits set");
    error_fmt_a: assert property (rd_i && addr_i == 6'h11 |=> rdata_o[23:20] == 4'h0)
        else $error("error count upper bits set");
endmodule
bind pvs_bank pvs_bank_chk pvs_bank_chk_i (.core_clk_i, .reset_i, .wr_i, .rd_i, .addr_i, .wdata_i,
    .rdata_o, .cal_voltage_o, .subband_o, .osc_en_o, .fb_buf_en_o, .out_div_en_o, .out_stage_en_o);

// ---- verification/pvs_host.sv ----
// Host model that reaches the bank through its strobe register port.
`timescale 1ns/100ps
module pvs_host (
    input  wire logic               core_clk_i, // System clock.
    input  wire pvs_pkg::pvs_word_t rdata_i,    // Read data from the bank.
    output logic                    wr_o,       // Write strobe.
    output logic                    rd_o,       // Read strobe.
    output pvs_pkg::pvs_addr_t      addr_o,     // Register address.
    output pvs_pkg::pvs_word_t      wdata_o     // Write data.
);
    import pvs_pkg::*;
    // The port starts idle.
    initial {wr_o, rd_o, addr_o, wdata_o} = '0;
    // One access; released data is inverted so stale values never look valid.
    task automatic access(input logic w, input pvs_addr_t a, input pvs_word_t d,
                          output pvs_word_t q);
        @(posedge core_clk_i);
        #1 {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
        @(posedge core_clk_i);
        #1 q = rdata_i;
        {wr_o, rd_o, wdata_o} = {2'b00, ~d};
    endtask
    // Subsystem writes travel only through main register 0x05.
    task automatic sub_write(input logic [2:0] id, input logic [3:0] ra, input pvs_sub_t v);
        pvs_word_t q;
        access(1'b1, 6'h05, {8'h00, v, ra, id}, q);
    endtask
endmodule

// ---- verification/pvs_bank_test.sv ----
// Self-checking testbench of the oscillator status and control bank.
`timescale 1ns/100ps
module pvs_bank_test;
    import pvs_pkg::*;
    logic        core_clk_i, reset_i, wr_i, rd_i, cal_start_i, cal_done_i, gen_out_i, lock_i;
    logic        cal_voltage_o, osc_en_o, fb_buf_en_o, out_div_en_o, out_stage_en_o;
    logic [7:0]  cal_switch_i, subband_o;
    logic [19:0] cal_error_i;
    pvs_addr_t   addr_i;
    pvs_word_t   wdata_i, rdata_o, q;
    pvs_sub_t    tun = 9'h020, en = 9'h1FF;
    int          error_cnt = 0, cmp_count = 0;
    pvs_addr_t   ra[8] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h00, 6'h01, 6'h05, 6'h3F};
    pvs_word_t   rv[8] = '{24'h000020, 24'h07FFFF, 24'h0, 24'h001259, 24'h0, 24'h0, 24'h0, 24'h0};
    logic [15:0] wt[8] = '{16'h01FF, 16'h0000, 16'h03DF, 16'h03F7, 16'h03FB, 16'h03FE, 16'h23FF, 16'h05FF};
    wire pvs_word_t ctl = {11'h0, subband_o, cal_voltage_o, osc_en_o, fb_buf_en_o, out_div_en_o, out_stage_en_o};
    pvs_bank pvs_bank_i (.core_clk_i, .reset_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .cal_start_i,
        .cal_done_i, .cal_switch_i, .cal_error_i, .gen_out_i, .lock_i, .cal_voltage_o, .subband_o,
        .osc_en_o, .fb_buf_en_o, .out_div_en_o, .out_stage_en_o);
    pvs_host pvs_host_i (.core_clk_i, .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
        .wdata_o(wdata_i));
    // Expected control outputs follow the enable gating of the subsystem.
    function automatic pvs_word_t exp_ctl(input pvs_sub_t t, input pvs_sub_t e);
        return {11'h0, t[8:1], t[0], e[0] & e[1], e[0] & e[2], e[0] & e[3], e[0] & e[3] & e[5]};
    endfunction
    // Compares one value and counts the outcome.
    task automatic check(input pvs_word_t seen, input pvs_word_t exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // Gives a one-cycle pulse on a calibration input.
    task automatic pulse(ref logic s);
        @(posedge core_clk_i);
        #1 s = 1'b1;
        @(posedge core_clk_i);
        #1 s = 1'b0;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("mismatches=%0d comparisons=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Free-running system clock.
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    // Cuts a hang short.
    initial begin
        #50000;
        error_cnt++;
        tally_and_finish;
    end
    // Main sequence of register accesses.
    initial begin
        {reset_i, cal_start_i, cal_done_i, gen_out_i, lock_i} = 5'b10000;
        {cal_switch_i, cal_error_i} = '0;
        repeat (20) @(posedge core_clk_i);
        #1 reset_i = 1'b0;
        check(ctl, exp_ctl(tun, en));
        for (int i = 0; i < 8; i++) begin
            pvs_host_i.access(1'b0, ra[i], 24'h0, q);
            check(q, rv[i]);
        end
        for (int i = 0; i < 8; i++) begin
            pvs_host_i.sub_write(wt[i][15:13], wt[i][12:9], wt[i][8:0]);
            if (wt[i][15:9] == 7'h00) tun = wt[i][8:0];
            if (wt[i][15:9] == 7'h01) en = wt[i][8:0];
            check(ctl, exp_ctl(tun, en));
        end
        pvs_host_i.access(1'b1, 6'h00, 24'hFFFFFF, q);
        check(ctl, exp_ctl(tun, en));
        {cal_switch_i, cal_error_i} = {8'hC3, 20'h80005};
        pulse(cal_start_i);
        pvs_host_i.access(1'b0, 6'h10, 24'h0, q);
        check(q, 24'h000120);
        pulse(cal_done_i);
        pvs_host_i.access(1'b0, 6'h10, 24'h0, q);
        check(q, 24'h0000C3);
        pvs_host_i.sub_write(3'h0, 4'h0, 9'h0AA);
        pvs_host_i.access(1'b0, 6'h10, 24'h0, q);
        check(q, 24'h0000C3);
        check({16'h0000, q[7:0]}, 24'h0000C3);
        pvs_host_i.access(1'b0, 6'h11, 24'h0, q);
        check(q, 24'h080005);
        cal_switch_i = 8'hFF;
        pulse(cal_start_i);
        pulse(cal_done_i);
        pvs_host_i.access(1'b0, 6'h10, 24'h0, q);
        check(q, 24'h0000FF);
        cal_switch_i = 8'h00;
        pulse(cal_done_i);
        pvs_host_i.access(1'b0, 6'h10, 24'h0, q);
        check(q, 24'h0000FF);
        for (int k = 1; k < 4; k++) begin
            {lock_i, gen_out_i} = k[1:0];
            repeat (8) @(posedge core_clk_i);
            pvs_host_i.access(1'b0, 6'h12, 24'h0, q);
            check(q, {22'h0, k[1:0]});
        end
        tally_and_finish;
    end
endmodule
